// ==== hdl/bbiq_pkg.sv ====
/*
  Constants for the baseband IQ user port: register map, control fields,
  enumerations and timing. Assumes a 250 MHz core clock.
*/
package bbiq_pkg;
  localparam int WORD_W = 18;
  localparam int POS_W  = 5;
  localparam int DIV_W  = 16;
  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CLKDIV  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RXCOUNT = 8'h0C;

  // control register fields
  localparam int B_ENABLE  = 0;
  localparam int B_TX      = 1;
  localparam int B_EXTCLK  = 2;
  localparam int B_SERIAL  = 3;
  localparam int B_DDR     = 4;
  localparam int B_ALIGNHI = 5;
  localparam int F_ILV     = 6;
  localparam int F_RATIO   = 8;
  localparam int B_MKPOL   = 11;
  localparam int F_WSIZE   = 16;
  localparam int F_MKBIT   = 24;

  localparam logic [31:0]      CTRL_RST   = 32'h0012_0000;
  localparam logic [DIV_W-1:0] CLKDIV_RST = 16'h0001;

  typedef enum logic [1:0] {
    ILV_NONE = 2'b00,
    ILV_IQ   = 2'b01,
    ILV_QI   = 2'b10
  } bbiq_ilv_t;

  typedef enum logic [2:0] {
    RAT_1    = 3'b000,
    RAT_4_5  = 3'b001,
    RAT_2_5  = 3'b010,
    RAT_1_5  = 3'b011,
    RAT_1_10 = 3'b100,
    RAT_1_20 = 3'b101
  } bbiq_ratio_t;

  // reference presence watchdog
  localparam int CLK_PERIOD_NS   = 4;
  localparam int REF_TIMEOUT_NS  = 1000;
  localparam int REF_TIMEOUT_CYC = REF_TIMEOUT_NS / CLK_PERIOD_NS;
endpackage

// ==== hdl/bbiq_port.sv ====
/*
  Baseband IQ user port: parallel/serial, interleaved IQ sample exchange
  with a device under test, transmit or receive, internal or external
  clock. Assumes a register master on core_clk and asynchronous pins;
  the bench resolves pin levels from the enables and pulls valid high.
*/
// What this block does
// - eighteen I lines and eighteen Q lines, words up to 18 bits
// - narrow parallel words sit at lowest or highest line, configurable
// - data lines driven in transmit, inputs in receive
// - fewer active lines for small words, interleaving or serial
// - data and clock always used; marker, valid optional; reference required under internal clocking
// - clock out: internal clock, or buffered copy of external clock
// - external clock input ignored under internal clocking
// - either clock source works with either direction
// - marker driven in transmit, sampled in receive
// - parallel interleaved: marker flags periods carrying the I word
// - serial: marker bit position and polarity configurable
// - serial plain: marker asserted at configured bit of each word
// - serial interleaved: marker from first component bit to second
// - transmit ratio below one inserts filler, valid low on filler
// - receive captures only periods with valid high
// - undriven valid reads high, so every period captured
// - reference input ignored under external clocking
// - sample rate halved by interleave, doubled by DDR, serial by size
// - sub-unity ratios only 4/5, 2/5, 1/5, 1/10, 1/20
// - data connections undriven while port is off
`timescale 1ns/1ns
module bbiq_port
  import bbiq_pkg::*;
#(
  parameter int W = WORD_W
)
(
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdData,
  // transmit samples from the instrument side
  input  wire logic [W-1:0]      txI,
  input  wire logic [W-1:0]      txQ,
  input  wire logic              txSmpValid,
  output logic                   txSmpTaken,
  // received samples toward the instrument side
  output logic      [W-1:0]      rxI,
  output logic      [W-1:0]      rxQ,
  output logic                   rxSmpStb,
  // user pins
  input  wire logic [W-1:0]      iDataIn,
  output logic      [W-1:0]      iDataOut,
  input  wire logic [W-1:0]      qDataIn,
  output logic      [W-1:0]      qDataOut,
  output logic                   dataOe,
  input  wire logic              userClockIn,
  output logic                   userClockOut,
  input  wire logic              refIn,
  input  wire logic              markerIn,
  output logic                   markerOut,
  output logic                   markerOe,
  input  wire logic              validIn,
  output logic                   validOut,
  output logic                   validOe
);

  function automatic logic [POS_W-1:0] wsEff(input logic [POS_W-1:0] ws);
    wsEff = (ws == '0 || ws > POS_W'(W)) ? POS_W'(W) : ws;
  endfunction

  function automatic logic [W-1:0] maskLow(input logic [POS_W-1:0] ws);
    maskLow = ~({W{1'b1}} << ws);
  endfunction

  function automatic logic [W-1:0] alignWord(input logic [W-1:0] w,
    input logic [POS_W-1:0] ws, input logic hi);
    alignWord = hi ? ((w & maskLow(ws)) << (POS_W'(W) - ws))
                   : (w & maskLow(ws));
  endfunction

  function automatic logic [W-1:0] unalignWord(input logic [W-1:0] w,
    input logic [POS_W-1:0] ws, input logic hi);
    unalignWord = hi ? (w >> (POS_W'(W) - ws)) : (w & maskLow(ws));
  endfunction

  // filler pattern: num valid slots out of den
  function automatic logic [POS_W-1:0] ratioNum(input bbiq_ratio_t r);
    case (r)
      RAT_4_5: ratioNum = 5'h04;
      RAT_2_5: ratioNum = 5'h02;
      default: ratioNum = 5'h01;
    endcase
  endfunction

  function automatic logic [POS_W-1:0] ratioDen(input bbiq_ratio_t r);
    case (r)
      RAT_4_5, RAT_2_5, RAT_1_5: ratioDen = 5'h05;
      RAT_1_10:                  ratioDen = 5'h0A;
      RAT_1_20:                  ratioDen = 5'h14;
      default:                   ratioDen = 5'h01;
    endcase
  endfunction

  // synchronisers: stage 1 feeds stage 2 only
  logic [W-1:0] iS1, iS2, qS1, qS2;
  logic         clkS1, clkS2, refS1, refS2, mkS1, mkS2, vlS1, vlS2;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      {iS1, iS2, qS1, qS2} <= '0;
      {clkS1, clkS2, refS1, refS2, mkS1, mkS2} <= '0;
      vlS1 <= 1'b1;
      vlS2 <= 1'b1;
    end
    else if (clkEn)
    begin
      iS1   <= iDataIn;
      iS2   <= iS1;
      qS1   <= qDataIn;
      qS2   <= qS1;
      clkS1 <= userClockIn;
      clkS2 <= clkS1;
      refS1 <= refIn;
      refS2 <= refS1;
      mkS1  <= markerIn;
      mkS2  <= mkS1;
      vlS1  <= validIn;
      vlS2  <= vlS1;
    end
  end

  logic [31:0]       ctrl_ff, nxt_ctrl;
  logic [DIV_W-1:0]  div_ff, nxt_div, divCnt_ff, nxt_divCnt;
  logic [31:0]       rxCnt_ff, nxt_rxCnt, rdData_ff, nxt_rdData;
  logic [7:0]        refTmr_ff, nxt_refTmr;
  logic              refOk_ff, nxt_refOk, refPrev_ff, intClk_ff, nxt_intClk;
  logic              srcPrev_ff, clkOut_ff, nxt_clkOut, mkPrev_ff;
  logic [POS_W-1:0]  pos_ff, nxt_pos, ratPh_ff, nxt_ratPh;
  logic              comp_ff, nxt_comp, slotVal_ff, nxt_slotVal;
  logic [W-1:0]      curI_ff, nxt_curI, curQ_ff, nxt_curQ;
  logic [W-1:0]      shI_ff, nxt_shI, shQ_ff, nxt_shQ;
  logic [W-1:0]      rxI_ff, nxt_rxI, rxQ_ff, nxt_rxQ;
  logic [W-1:0]      iOut_ff, nxt_iOut, qOut_ff, nxt_qOut;
  logic              rxStb_ff, nxt_rxStb, taken_ff, nxt_taken;
  logic              mkOut_ff, nxt_mkOut, vlOut_ff, nxt_vlOut, oe_ff, nxt_oe;

  logic              en, tx, ext, ser, ddr, hi, mkPol, ilvOn;
  bbiq_ilv_t         ilv;
  bbiq_ratio_t       ratio;
  logic [POS_W-1:0]  ws, mkBit, lastPos;
  logic              srcClk, tick, start, isI, wrap, mkAct;
  logic [W-1:0]      useI, useQ, word;

  always_comb
  begin
    en     = ctrl_ff[B_ENABLE];
    tx     = ctrl_ff[B_TX];
    ext    = ctrl_ff[B_EXTCLK];
    ser    = ctrl_ff[B_SERIAL];
    ddr    = ctrl_ff[B_DDR];
    hi     = ctrl_ff[B_ALIGNHI];
    mkPol  = ctrl_ff[B_MKPOL];
    ilv    = bbiq_ilv_t'(ctrl_ff[F_ILV +: 2]);
    ratio  = bbiq_ratio_t'(ctrl_ff[F_RATIO +: 3]);
    ws     = wsEff(ctrl_ff[F_WSIZE +: POS_W]);
    mkBit  = ctrl_ff[F_MKBIT +: POS_W];
    ilvOn  = (ilv != ILV_NONE);
    lastPos = ser ? ws - 5'h01 : '0;
    // other source's clock never reaches the edge finder
    srcClk = ext ? clkS2 : intClk_ff;
    tick   = en & ((srcClk & ~srcPrev_ff)
                   | (ddr & ~srcClk & srcPrev_ff));
    start  = (pos_ff == '0) && !comp_ff;
    wrap   = (pos_ff == lastPos) && (comp_ff || !ilvOn);
    isI    = (ilv == ILV_QI) ? comp_ff : !comp_ff;
    // marker in receive is sampled the same way as it is driven
    mkAct  = mkS2 ^ (ser & mkPol);

    nxt_ctrl = ctrl_ff;
    nxt_div  = div_ff;
    if (regWr && regAddr == ADDR_CTRL)
      nxt_ctrl = regWrData;
    if (regWr && regAddr == ADDR_CLKDIV)
      nxt_div = (regWrData[DIV_W-1:0] == '0) ? CLKDIV_RST
                                              : regWrData[DIV_W-1:0];
    // unlisted ratio codes fall back to one sample per slot
    if (nxt_ctrl[F_RATIO +: 3] > RAT_1_20)
      nxt_ctrl[F_RATIO +: 3] = RAT_1;

    // reference watchdog, only meaningful under internal clocking
    nxt_refTmr = refTmr_ff;
    nxt_refOk  = refOk_ff;
    if (ext)
    begin
      nxt_refTmr = '0;
      nxt_refOk  = 1'b0;
    end
    else if (refS2 != refPrev_ff)
    begin
      nxt_refTmr = '0;
      nxt_refOk  = 1'b1;
    end
    else if (refTmr_ff == 8'(REF_TIMEOUT_CYC))
      nxt_refOk = 1'b0;
    else
      nxt_refTmr = refTmr_ff + 8'h01;

    nxt_divCnt = '0;
    nxt_intClk = 1'b0;
    if (en && !ext && refOk_ff)
    begin
      nxt_intClk = intClk_ff;
      nxt_divCnt = divCnt_ff + 16'h0001;
      if (divCnt_ff >= div_ff - 16'h0001)
      begin
        nxt_divCnt = '0;
        nxt_intClk = ~intClk_ff;
      end
    end
    nxt_clkOut = en & srcClk;

    nxt_pos = pos_ff;
    nxt_comp = comp_ff;
    nxt_ratPh = ratPh_ff;
    nxt_slotVal = slotVal_ff;
    nxt_curI = curI_ff;
    nxt_curQ = curQ_ff;
    nxt_shI = shI_ff;
    nxt_shQ = shQ_ff;
    nxt_rxI = rxI_ff;
    nxt_rxQ = rxQ_ff;
    nxt_rxStb = 1'b0;
    nxt_taken = 1'b0;
    nxt_iOut = iOut_ff;
    nxt_qOut = qOut_ff;
    nxt_mkOut = mkOut_ff;
    nxt_vlOut = vlOut_ff;
    nxt_rxCnt = rxCnt_ff;
    useI = curI_ff;
    useQ = curQ_ff;
    word = '0;
    nxt_oe = en & tx;

    if (!en || regWr)
    begin
      nxt_pos = '0;
      nxt_comp = 1'b0;
      nxt_ratPh = '0;
      nxt_slotVal = 1'b0;
      nxt_iOut = '0;
      nxt_qOut = '0;
      nxt_mkOut = 1'b0;
      nxt_vlOut = 1'b0;
    end
    else if (tick && tx)
    begin
      if (start)
      begin
        nxt_slotVal = (ratPh_ff < ratioNum(ratio)) && txSmpValid;
        nxt_taken = nxt_slotVal;
        nxt_ratPh = (ratPh_ff >= ratioDen(ratio) - 5'h01) ? '0
                    : ratPh_ff + 5'h01;
        useI = nxt_slotVal ? txI : '0; // filler words are zero
        useQ = nxt_slotVal ? txQ : '0;
        nxt_curI = useI;
        nxt_curQ = useQ;
      end
      nxt_vlOut = nxt_slotVal;
      word = isI ? useI : useQ;
      nxt_iOut = '0;
      nxt_qOut = '0;
      if (!ser && !ilvOn)
      begin
        nxt_iOut = alignWord(useI, ws, hi);
        nxt_qOut = alignWord(useQ, ws, hi);
        nxt_mkOut = 1'b0;
      end
      else if (!ser)
      begin
        nxt_iOut = alignWord(word, ws, hi);
        nxt_mkOut = isI;
      end
      else
      begin
        if (ilvOn)
        begin
          nxt_iOut[0] = word[lastPos - pos_ff];
          nxt_mkOut = mkPol ^ (comp_ff ? pos_ff <= mkBit
                                       : pos_ff >= mkBit);
        end
        else
        begin
          nxt_iOut[0] = useI[lastPos - pos_ff];
          nxt_qOut[0] = useQ[lastPos - pos_ff];
          nxt_mkOut = mkPol ^ (pos_ff == mkBit);
        end
      end
    end
    else if (tick && vlS2) // pull-up keeps vlS2 high if undriven
    begin
      if (!ser && !ilvOn)
      begin
        nxt_rxI = unalignWord(iS2, ws, hi);
        nxt_rxQ = unalignWord(qS2, ws, hi);
        nxt_rxStb = 1'b1;
      end
      else if (!ser)
      begin
        // marker names the I word; pair completes on the Q word
        if (mkS2)
          nxt_shI = unalignWord(iS2, ws, hi);
        else
        begin
          nxt_rxI = shI_ff;
          nxt_rxQ = unalignWord(iS2, ws, hi);
          nxt_rxStb = 1'b1;
        end
      end
      else
      begin
        if (mkAct && !mkPrev_ff)
        begin
          nxt_pos = mkBit; // realign word framing on marker start
          nxt_comp = 1'b0;
        end
        else
          nxt_pos = pos_ff;
        if (ilvOn && ((ilv == ILV_QI) ? nxt_comp : !nxt_comp))
          nxt_shI = {shI_ff[W-2:0], iS2[0]};
        else if (ilvOn)
          nxt_shQ = {shQ_ff[W-2:0], iS2[0]};
        else
        begin
          nxt_shI = {shI_ff[W-2:0], iS2[0]};
          nxt_shQ = {shQ_ff[W-2:0], qS2[0]};
        end
        if (nxt_pos == lastPos && (nxt_comp || !ilvOn))
        begin
          nxt_rxI = nxt_shI & maskLow(ws);
          nxt_rxQ = nxt_shQ & maskLow(ws);
          nxt_rxStb = 1'b1;
        end
      end
    end
    if (en && !regWr && tick)
    begin
      // serial position advances per transfer, restart at word end
      if (!ser && !ilvOn)
        nxt_comp = 1'b0;
      else if (!ser)
        nxt_comp = tx ? ~comp_ff : 1'b0;
      else if ((tx ? pos_ff : nxt_pos) == lastPos)
      begin
        nxt_pos = '0;
        nxt_comp = ilvOn & ~(tx ? comp_ff : nxt_comp);
      end
      else
        nxt_pos = (tx ? pos_ff : nxt_pos) + 5'h01;
    end
    if (nxt_rxStb)
      nxt_rxCnt = rxCnt_ff + 32'h0000_0001;

    nxt_rdData = '0;
    if (regRd)
      case (regAddr)
        ADDR_CTRL:    nxt_rdData = ctrl_ff;
        ADDR_CLKDIV:  nxt_rdData = {16'h0000, div_ff};
        ADDR_STATUS:  nxt_rdData = {28'h0000000, slotVal_ff, wrap,
                                    srcClk, refOk_ff};
        ADDR_RXCOUNT: nxt_rdData = rxCnt_ff;
        default:      nxt_rdData = '0;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctrl_ff <= CTRL_RST;
      div_ff <= CLKDIV_RST;
      {divCnt_ff, rxCnt_ff, rdData_ff, refTmr_ff} <= '0;
      {refOk_ff, refPrev_ff, intClk_ff, srcPrev_ff, clkOut_ff} <= '0;
      {mkPrev_ff, pos_ff, ratPh_ff, comp_ff, slotVal_ff} <= '0;
      {curI_ff, curQ_ff, shI_ff, shQ_ff, rxI_ff, rxQ_ff} <= '0;
      {iOut_ff, qOut_ff, rxStb_ff, taken_ff} <= '0;
      {mkOut_ff, vlOut_ff, oe_ff} <= '0;
    end
    else if (clkEn)
    begin
      ctrl_ff <= nxt_ctrl;
      div_ff <= nxt_div;
      divCnt_ff <= nxt_divCnt;
      rxCnt_ff <= nxt_rxCnt;
      rdData_ff <= nxt_rdData;
      refTmr_ff <= nxt_refTmr;
      refOk_ff <= nxt_refOk;
      refPrev_ff <= refS2;
      intClk_ff <= nxt_intClk;
      srcPrev_ff <= srcClk;
      clkOut_ff <= nxt_clkOut;
      mkPrev_ff <= mkAct;
      pos_ff <= nxt_pos;
      ratPh_ff <= nxt_ratPh;
      comp_ff <= nxt_comp;
      slotVal_ff <= nxt_slotVal;
      curI_ff <= nxt_curI;
      curQ_ff <= nxt_curQ;
      shI_ff <= nxt_shI;
      shQ_ff <= nxt_shQ;
      rxI_ff <= nxt_rxI;
      rxQ_ff <= nxt_rxQ;
      iOut_ff <= nxt_iOut;
      qOut_ff <= nxt_qOut;
      rxStb_ff <= nxt_rxStb;
      taken_ff <= nxt_taken;
      mkOut_ff <= nxt_mkOut;
      vlOut_ff <= nxt_vlOut;
      oe_ff <= nxt_oe;
    end
  end

  assign regRdData    = rdData_ff;
  assign txSmpTaken   = taken_ff;
  assign rxI          = rxI_ff;
  assign rxQ          = rxQ_ff;
  assign rxSmpStb     = rxStb_ff;
  assign iDataOut     = iOut_ff;
  assign qDataOut     = qOut_ff;
  assign dataOe       = oe_ff;
  assign userClockOut = clkOut_ff;
  assign markerOut    = mkOut_ff;
  assign markerOe     = oe_ff;
  assign validOut     = vlOut_ff;
  assign validOe      = oe_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst || !clkEn);

  a_oe_when_off: assert property ($past(!en) |-> !oe_ff)
    else $error("pins driven while port off");
  a_oe_rx_dir: assert property ($past(en && !tx) |-> !dataOe)
    else $error("data pins driven in receive");
  a_clk_ext_copy: assert property (ext && en
    |=> clkOut_ff == $past(clkS2))
    else $error("clock out not a copy of external clock");
  a_ref_ignored: assert property (ext |=> !intClk_ff && !refOk_ff)
    else $error("reference acted on under external clock");
  a_ext_ignored: assert property (!ext && en
    |=> clkOut_ff == $past(intClk_ff))
    else $error("external clock reached clock out");
  a_taken_valid: assert property (taken_ff
    |-> vlOut_ff && slotVal_ff)
    else $error("sample taken on filler slot");
  a_rx_gated: assert property (rxStb_ff
    |-> $past(vlS2) && $past(tick))
    else $error("capture without valid");
  a_mk_ilv_par: assert property (en && tx && !ser && ilvOn && tick
    && !regWr |=> mkOut_ff == $past(isI) && $past(comp_ff) != comp_ff)
    else $error("marker does not flag I word");
endmodule

// ==== testbench/bbiq_dut_model.sv ====
/*
  Behavioural far-side device for the baseband IQ port: external link
  clock, frequency reference, receive data and a valid gating pattern.
  Assumes the bench resolves each shared pin from both parties' enables.
*/
`timescale 1ns/1ns
module bbiq_dut_model (
  // controls from the bench
  input  wire logic        clkRun,
  input  wire logic        refRun,
  input  wire logic        dataEn,
  // pins toward the port
  output logic             userClockIn,
  output logic             refIn,
  output logic             validDrv,
  output logic [17:0]      iDrv,
  output logic [17:0]      qDrv
);
  logic [17:0] k;

  initial
  begin
    userClockIn = 1'b0;
    refIn = 1'b0;
    k = 18'h0;
  end

  // 160 ns link clock, never paused while external clocking is in use
  always #80 if (clkRun) userClockIn = ~userClockIn;
  // reference kept alive so the internal clock can run
  always #50 if (refRun) refIn = ~refIn;

  // data moves on the falling edge, away from the capturing edge
  always @(negedge userClockIn) k <= k + 18'h1;

  // released lines show a changing pattern, not the last value
  assign iDrv     = dataEn ? k : ~k;
  assign qDrv     = dataEn ? ~k : k;
  // every other period gated out of the capture window
  assign validDrv = k[0];
endmodule

// ==== testbench/bbiq_port_tb.sv ====
/*
  Self-checking bench for the baseband IQ port: registers, transmit
  alignment and rates, marker timing, receive gating and clock sources.
  Assumes the far-side model is compiled before this file.
*/
`timescale 1ns/1ns
module bbiq_port_tb;
  import bbiq_pkg::*;

  logic              core_clk, sys_rst, clkEn, regWr, regRd;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData, regRdData;
  logic [17:0]       txI, txQ, rxI, rxQ, iDrv, qDrv;
  logic [17:0]       iDataIn, iDataOut, qDataIn, qDataOut;
  logic              txSmpValid, txSmpTaken, rxSmpStb, dataOe;
  logic              userClockIn, userClockOut, refIn, lastClk;
  logic              markerIn, markerOut, markerOe;
  logic              validIn, validOut, validOe, validDrv;
  logic              clkRun, refRun, dataEn, validEn;
  int                miscompares, num_checks, cyc;
  int                nTk, nStb, nClk, nMk;

  assign iDataIn  = dataOe ? iDataOut : iDrv;
  assign qDataIn  = dataOe ? qDataOut : qDrv;
  assign markerIn = markerOe ? markerOut : iDrv[1];
  // pull-up holds valid high when no party drives it
  assign validIn  = validOe ? validOut : (validEn ? validDrv : 1'b1);

  bbiq_port dut_u (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .clkEn        (clkEn),
    .regAddr      (regAddr),
    .regWrData    (regWrData),
    .regWr        (regWr),
    .regRd        (regRd),
    .regRdData    (regRdData),
    .txI          (txI),
    .txQ          (txQ),
    .txSmpValid   (txSmpValid),
    .txSmpTaken   (txSmpTaken),
    .rxI          (rxI),
    .rxQ          (rxQ),
    .rxSmpStb     (rxSmpStb),
    .iDataIn      (iDataIn),
    .iDataOut     (iDataOut),
    .qDataIn      (qDataIn),
    .qDataOut     (qDataOut),
    .dataOe       (dataOe),
    .userClockIn  (userClockIn),
    .userClockOut (userClockOut),
    .refIn        (refIn),
    .markerIn     (markerIn),
    .markerOut    (markerOut),
    .markerOe     (markerOe),
    .validIn      (validIn),
    .validOut     (validOut),
    .validOe      (validOe)
  );

  bbiq_dut_model dev_u (
    .clkRun      (clkRun),
    .refRun      (refRun),
    .dataEn      (dataEn),
    .userClockIn (userClockIn),
    .refIn       (refIn),
    .validDrv    (validDrv),
    .iDrv        (iDrv),
    .qDrv        (qDrv)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // generous ceiling: the whole run needs about 10000 cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      $display("[FAIL] %0t run did not finish in time", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk(regRdData, e);
  endtask

  // writes a setting, lets the link settle, then watches n cycles
  task automatic meas(input logic [31:0] c, input int n, input int mode);
    wr(ADDR_CTRL, c);
    repeat (8) @(negedge core_clk);
    nTk = 0;
    nStb = 0;
    nClk = 0;
    nMk = 0;
    lastClk = userClockOut;
    repeat (n)
    begin
      @(negedge core_clk);
      nTk += txSmpTaken;
      nStb += rxSmpStb;
      nMk += markerOut;
      nClk += (userClockOut && !lastClk);
      lastClk = userClockOut;
      if (validOe === 1'b1 && validOut === 1'b0)
        chk(iDataOut, 32'h0);
      if (mode == 1 || mode == 2)
      begin
        chk(markerOut, iDataOut[0] ^ (mode == 2));
        chk(iDataOut[17:1], 32'h0);
      end
      if (mode == 3 && validOut === 1'b1)
        chk(iDataOut, markerOut ? txI : txQ);
      if (rxSmpStb === 1'b1)
        chk(rxQ ^ rxI, 32'h3FFFF);
      if (mode == 4 && rxSmpStb === 1'b1)
        chk(rxI[0], 1'b1);
    end
  endtask

  task automatic t_regs();
    chk({dataOe, markerOe, validOe}, 32'h0);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_CLKDIV, 32'h0000_0001);
    rd(8'h10, 32'h0);
    wr(ADDR_CLKDIV, 32'h0);
    rd(ADDR_CLKDIV, 32'h0000_0001);
    // ratio code above the table is not kept
    wr(ADDR_CTRL, 32'h0012_0700);
    rd(ADDR_CTRL, 32'h0012_0000);
    $display("test regs done");
  endtask

  task automatic t_tx();
    logic [17:0] ei;
    logic [17:0] eq;
    wr(ADDR_CLKDIV, 32'h0000_0002);
    txI <= 18'h0ABCD;
    txQ <= 18'h01234;
    for (int hi = 0; hi < 2; hi++)
    begin
      ei = hi ? 18'h2AF34 : 18'h0ABCD;
      eq = hi ? 18'h048D0 : 18'h01234;
      wr(ADDR_CTRL, hi ? 32'h0010_0023 : 32'h0010_0003);
      repeat (2) @(negedge core_clk);
      for (int i = 0; i < 100 && txSmpTaken !== 1'b1; i++)
        @(negedge core_clk);
      chk(iDataOut, ei);
      chk(qDataOut, eq);
      chk(dataOe, 1'b1);
      chk(validOut, 1'b1);
    end
    $display("test tx_par done");
  endtask

  // samples taken per 100 link periods for each framing and ratio
  task automatic t_rates();
    logic [31:0] c [9];
    int          e [9];
    c = '{32'h0012_0003, 32'h0012_0103, 32'h0012_0203, 32'h0012_0303,
          32'h0012_0403, 32'h0012_0503, 32'h0012_0013, 32'h0012_0043,
          32'h0008_000B};
    e = '{100, 80, 40, 20, 10, 5, 200, 50, 12};
    @(posedge core_clk);
    txI <= 18'h00155;
    txQ <= 18'h002AA;
    for (int i = 0; i < 9; i++)
    begin
      meas(c[i], 400, (i == 7) ? 3 : 0);
      chk_rng(nTk, e[i] - 2, e[i] + 2);
      chk_rng(nClk, 99, 101);
      if (i == 7)
        chk_rng(nMk, 192, 208);
    end
    $display("test rates done");
  endtask

  task automatic t_marker();
    @(posedge core_clk);
    txI <= 18'h00010;
    txQ <= 18'h00010;
    meas(32'h0308_000B, 640, 1);
    chk_rng(nMk, 72, 88);
    meas(32'h0308_080B, 640, 2);
    chk_rng(nMk, 552, 568);
    meas(32'h0308_004B, 640, 0);
    chk_rng(nMk, 352, 368);
    meas(32'h0308_008B, 640, 0);
    chk_rng(nMk, 352, 368);
    $display("test marker done");
  endtask

  task automatic t_rx();
    // external clock with the reference removed
    refRun <= 1'b0;
    meas(32'h0012_0005, 800, 4);
    chk_rng(nStb, 9, 11);
    chk_rng(nClk, 19, 21);
    chk(dataOe, 1'b0);
    // double rate receive: each gated-in word is seen on both edges
    meas(32'h0012_0015, 800, 4);
    chk_rng(nStb, 18, 22);
    validEn <= 1'b0;
    meas(32'h0012_0005, 800, 0);
    chk_rng(nStb, 19, 21);
    meas(32'h0012_0007, 800, 0);
    chk_rng(nTk, 19, 21);
    // internal clock in receive direction
    refRun <= 1'b1;
    validEn <= 1'b1;
    meas(32'h0012_0001, 400, 0);
    chk_rng(nStb, 45, 55);
    wr(ADDR_CTRL, 32'h0012_0002);
    repeat (2) @(negedge core_clk);
    chk({dataOe, markerOe, validOe}, 32'h0);
    $display("test rx done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    txI = 18'h0;
    txQ = 18'h0;
    txSmpValid = 1'b1;
    clkRun = 1'b1;
    refRun = 1'b1;
    dataEn = 1'b1;
    validEn = 1'b1;
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_tx();
    t_rates();
    t_marker();
    t_rx();
    results();
  end
endmodule
